/* aud_core.sv */
// Purpose : audio unit control and status core behind an AXI4-Lite slave
// Assumes : DMA and converter handshakes run on i_mclk; one write and one read at a time
// Notes   : unmapped addresses answer SLVERR; all registers are 16 bits in the low half
// Summary of operation
// - bits 3 and 2 show speaker output and speaker buffer holding valid data
// - bits 1 and 0 show microphone input and microphone buffer holding valid data
// - software writes into data registers never set the matching valid flag
// - valid-flag register writes accepted only while speaker or microphone enabled
// - disabled speaker or microphone holds its two valid flags at zero
// - sequence bit 15 holds the datapath and interrupt flags in reset while one
// - sequence bit 4 enables microphone block and its DMA
// - sequence bit 0 enables speaker block and its DMA
// - new A/D sample while input valid and buffer full sets loss flag, overwrites input
// - loading the microphone buffer sets the receive-complete flag
// - D/A hand-off without valid output sets mute, once output was valid
// - interrupt flags are sticky, cleared by writing one
// - reserved bits of valid, sequence and interrupt registers read zero
// - empty output takes the speaker buffer, then DMA refills the buffer
// - input sample moves to microphone buffer, then DMA request writes it out
// - conversion interval is the 16-bit divisor in clock cycles
//
// Added by the designer: the AXI4-Lite interface to the registers.
module aud_core
  import aud_pkg::*;
(
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  // axi4-lite write
  input  wire logic [31:0]             i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output logic [1:0]                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  // axi4-lite read
  input  wire logic [31:0]             i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output logic [1:0]                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  // speaker dma and d/a
  output logic                         o_spk_dma_req,
  input  wire logic                    i_spk_dma_ack,
  input  wire logic [AUD_SAMPLE_W-1:0] i_spk_dma_data,
  output logic                         o_dac_stb,
  output logic [AUD_SAMPLE_W-1:0]      o_dac_data,
  // microphone a/d and dma
  output logic                         o_adc_req,
  input  wire logic                    i_adc_ack,
  input  wire logic [AUD_SAMPLE_W-1:0] i_adc_data,
  output logic                         o_mic_dma_req,
  input  wire logic                    i_mic_dma_ack,
  output logic [AUD_SAMPLE_W-1:0]      o_mic_dma_data,
  // interrupt
  output logic                         o_irq
);

  typedef struct packed {
    logic        soft_rst;
    logic        mic_en;
    logic        spk_en;
    logic        spk_out_v;
    logic        spk_buf_v;
    logic        mic_in_v;
    logic        mic_buf_v;
    logic        f_loss;
    logic        f_rx;
    logic        f_mute;
    logic        m_loss;
    logic        m_rx;
    logic        m_mute;
    logic [15:0] spk_div;
    logic [15:0] mic_div;
    logic [9:0]  spk_out;
    logic [9:0]  spk_buf;
    logic [9:0]  mic_in;
    logic [9:0]  mic_buf;
    logic [9:0]  dac_data;
    logic        dac_stb;
    logic        mute_arm;
    logic        aw_got;
    logic [31:0] awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } aud_state_t;

  aud_state_t  st_r;
  aud_state_t  st_nxt;
  logic        spk_tick;
  logic        mic_tick;
  logic        wr_do;
  logic        wr_valid;
  logic [15:0] wv;
  logic [15:0] rd16;
  logic        rd_hit;

  // byte lanes 0 and 1 carry the 16-bit register, upper lanes are ignored
  function automatic logic [15:0] aud_merge(input logic [15:0] o,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
    logic [15:0] r;
    r       = o;
    if (s[0])
      r[7:0]  = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    return r;
  endfunction : aud_merge

  // ****************************************************************
  // conversion timers
  // ****************************************************************
  // microphone interval
  aud_rate_timer u_mic_tmr
  (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_run     (st_r.mic_en && !st_r.soft_rst),
    .i_divisor (st_r.mic_div),
    .o_tick    (mic_tick)
  );

  aud_rate_timer u_spk_tmr
  (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_run     (st_r.spk_en && !st_r.soft_rst),
    .i_divisor (st_r.spk_div),
    .o_tick    (spk_tick)
  );

  // ****************************************************************
  // register read view
  // ****************************************************************
  always_comb
  begin
    rd16   = 16'h0000;
    rd_hit = 1'b1;
    unique case (i_araddr)
      AUD_A_VALID:
      begin
        rd16[AUD_B_SPK_OUT_V] = st_r.spk_out_v;
        rd16[AUD_B_SPK_BUF_V] = st_r.spk_buf_v;
        rd16[AUD_B_MIC_IN_V]  = st_r.mic_in_v;
        rd16[AUD_B_MIC_BUF_V] = st_r.mic_buf_v;
      end
      AUD_A_SEQ:
      begin
        rd16[AUD_B_SOFT_RST] = st_r.soft_rst;
        rd16[AUD_B_MIC_EN]   = st_r.mic_en;
        rd16[AUD_B_SPK_EN]   = st_r.spk_en;
      end
      AUD_A_INT:
      begin
        rd16[AUD_B_LOSS]    = st_r.f_loss;
        rd16[AUD_B_RX_DONE] = st_r.f_rx;
        rd16[AUD_B_MUTE]    = st_r.f_mute;
      end
      AUD_A_MASK:
      begin
        rd16[AUD_B_LOSS]    = st_r.m_loss;
        rd16[AUD_B_RX_DONE] = st_r.m_rx;
        rd16[AUD_B_MUTE]    = st_r.m_mute;
      end
      AUD_A_SPK_DIV: rd16 = st_r.spk_div;
      AUD_A_MIC_DIV: rd16 = st_r.mic_div;
      AUD_A_SPK_OUT: rd16[9:0] = st_r.spk_out;
      AUD_A_SPK_BUF: rd16[9:0] = st_r.spk_buf;
      AUD_A_MIC_IN:  rd16[9:0] = st_r.mic_in;
      AUD_A_MIC_BUF: rd16[9:0] = st_r.mic_buf;
      default:       rd_hit = 1'b0;
    endcase
  end

  assign wr_do    = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_valid = wr_do && st_r.awaddr == AUD_A_VALID;
  assign wv       = aud_merge(16'h0000, st_r.wdata, st_r.wstrb);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.dac_stb = 1'b0;

    // bus handshakes: address and data taken in either order
    if (i_awvalid && o_awready)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    if (st_r.bvalid && i_bready)
      st_nxt.bvalid = 1'b0;
    if (st_r.rvalid && i_rready)
      st_nxt.rvalid = 1'b0;
    if (i_arvalid && o_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = {16'h0000, rd16};
      st_nxt.rresp  = rd_hit ? AUD_RESP_OKAY : AUD_RESP_SLV;
    end

    // register writes
    if (wr_do)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = AUD_RESP_OKAY;
      unique case (st_r.awaddr)
        AUD_A_VALID:
        begin
          if (st_r.spk_en || st_r.mic_en)
          begin
            st_nxt.spk_out_v = wv[AUD_B_SPK_OUT_V];
            st_nxt.spk_buf_v = wv[AUD_B_SPK_BUF_V];
            st_nxt.mic_in_v  = wv[AUD_B_MIC_IN_V];
            st_nxt.mic_buf_v = wv[AUD_B_MIC_BUF_V];
          end
        end
        AUD_A_SEQ:
        begin
          if (st_r.wstrb[1])
            st_nxt.soft_rst = wv[AUD_B_SOFT_RST];
          if (st_r.wstrb[0])
          begin
            st_nxt.mic_en = wv[AUD_B_MIC_EN];
            st_nxt.spk_en = wv[AUD_B_SPK_EN];
          end
        end
        AUD_A_INT:
        begin
          st_nxt.f_loss = st_r.f_loss && !wv[AUD_B_LOSS];
          st_nxt.f_rx   = st_r.f_rx && !wv[AUD_B_RX_DONE];
          st_nxt.f_mute = st_r.f_mute && !wv[AUD_B_MUTE];
        end
        AUD_A_MASK:
        begin
          if (st_r.wstrb[1])
          begin
            st_nxt.m_loss = wv[AUD_B_LOSS];
            st_nxt.m_rx   = wv[AUD_B_RX_DONE];
          end
          if (st_r.wstrb[0])
            st_nxt.m_mute = wv[AUD_B_MUTE];
        end
        AUD_A_SPK_DIV: st_nxt.spk_div = aud_merge(st_r.spk_div, st_r.wdata, st_r.wstrb);
        AUD_A_MIC_DIV: st_nxt.mic_div = aud_merge(st_r.mic_div, st_r.wdata, st_r.wstrb);
        AUD_A_SPK_OUT: st_nxt.spk_out = wv[9:0];
        AUD_A_SPK_BUF: st_nxt.spk_buf = wv[9:0];
        AUD_A_MIC_IN:  st_nxt.mic_in  = wv[9:0];
        AUD_A_MIC_BUF: st_nxt.mic_buf = wv[9:0];
        default:       st_nxt.bresp   = AUD_RESP_SLV;
      endcase
    end

    // speaker path; hardware events land after software so a set beats a clear
    if (st_r.spk_en && !st_r.soft_rst)
    begin
      if (spk_tick)
      begin
        if (st_r.spk_out_v)
        begin
          st_nxt.dac_data  = st_r.spk_out;
          st_nxt.dac_stb   = 1'b1;
          st_nxt.spk_out_v = 1'b0;
        end
        else if (st_r.mute_arm)
          st_nxt.f_mute = 1'b1;
      end
      if (!st_r.spk_out_v && st_r.spk_buf_v)
      begin
        st_nxt.spk_out   = st_r.spk_buf;
        st_nxt.spk_out_v = 1'b1;
        st_nxt.spk_buf_v = 1'b0;
      end
      else if (i_spk_dma_ack && !st_r.spk_buf_v)
      begin
        st_nxt.spk_buf   = i_spk_dma_data;
        st_nxt.spk_buf_v = 1'b1;
      end
      if (st_r.spk_out_v)
        st_nxt.mute_arm = 1'b1;
    end

    // microphone path
    if (st_r.mic_en && !st_r.soft_rst)
    begin
      if (i_mic_dma_ack && st_r.mic_buf_v)
        st_nxt.mic_buf_v = 1'b0;
      if (st_r.mic_in_v && !st_r.mic_buf_v)
      begin
        st_nxt.mic_buf   = st_r.mic_in;
        st_nxt.mic_buf_v = 1'b1;
        st_nxt.mic_in_v  = 1'b0;
        st_nxt.f_rx      = 1'b1;
      end
      if (i_adc_ack)
      begin
        if (st_nxt.mic_in_v)
          st_nxt.f_loss = 1'b1;
        st_nxt.mic_in   = i_adc_data;
        st_nxt.mic_in_v = 1'b1;
      end
    end

    if (!st_nxt.spk_en)
    begin
      st_nxt.spk_out_v = 1'b0;
      st_nxt.spk_buf_v = 1'b0;
      st_nxt.mute_arm  = 1'b0;
    end
    if (!st_nxt.mic_en)
    begin
      st_nxt.mic_in_v  = 1'b0;
      st_nxt.mic_buf_v = 1'b0;
      st_nxt.mic_in    = AUD_MIC_IN_IDL;
    end

    // soft reset clears datapath, keeps bus and sequence bits
    if (st_nxt.soft_rst)
    begin
      st_nxt.spk_out_v = 1'b0;
      st_nxt.spk_buf_v = 1'b0;
      st_nxt.mic_in_v  = 1'b0;
      st_nxt.mic_buf_v = 1'b0;
      st_nxt.f_loss    = 1'b0;
      st_nxt.f_rx      = 1'b0;
      st_nxt.f_mute    = 1'b0;
      st_nxt.mute_arm  = 1'b0;
      st_nxt.dac_stb   = 1'b0;
      st_nxt.spk_out   = AUD_SAMPLE_RST;
      st_nxt.spk_buf   = AUD_SAMPLE_RST;
      st_nxt.mic_buf   = AUD_SAMPLE_RST;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      st_r         <= '0;
      st_r.m_loss  <= AUD_MASK_RST;
      st_r.m_rx    <= AUD_MASK_RST;
      st_r.m_mute  <= AUD_MASK_RST;
      st_r.spk_div <= AUD_DIV_RST;
      st_r.mic_div <= AUD_DIV_RST;
      st_r.mic_in  <= AUD_MIC_IN_IDL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_awready      = !st_r.aw_got && !st_r.bvalid;
  assign o_wready       = !st_r.w_got && !st_r.bvalid;
  assign o_bvalid       = st_r.bvalid;
  assign o_bresp        = st_r.bresp;
  assign o_arready      = !st_r.rvalid;
  assign o_rvalid       = st_r.rvalid;
  assign o_rdata        = st_r.rdata;
  assign o_rresp        = st_r.rresp;
  assign o_spk_dma_req  = st_r.spk_en && !st_r.soft_rst && !st_r.spk_buf_v;
  assign o_dac_stb      = st_r.dac_stb;
  assign o_dac_data     = st_r.dac_data;
  assign o_adc_req      = mic_tick;
  assign o_mic_dma_req  = st_r.mic_en && !st_r.soft_rst && st_r.mic_buf_v;
  assign o_mic_dma_data = st_r.mic_buf;
  assign o_irq = (st_r.f_loss && st_r.m_loss) || (st_r.f_rx && st_r.m_rx) ||
                 (st_r.f_mute && st_r.m_mute);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  spk_off_flags_a: assert property (!st_r.spk_en |-> !st_r.spk_out_v && !st_r.spk_buf_v)
    else $error("speaker valid flag set while speaker disabled");

  mic_off_flags_a: assert property (!st_r.mic_en |-> !st_r.mic_in_v && !st_r.mic_buf_v)
    else $error("microphone valid flag set while microphone disabled");

  debug_wr_gate_a: assert property (
    (wr_valid && !st_r.spk_en && !st_r.mic_en && !st_nxt.spk_en && !st_nxt.mic_en)
      |=> !st_r.spk_out_v && !st_r.mic_in_v)
    else $error("valid register write accepted while both paths disabled");

  // same-cycle check: the cycle that releases soft reset may raise a dma request next
  soft_rst_clear_a: assert property (st_r.soft_rst |->
    !st_r.f_loss && !st_r.f_rx && !st_r.f_mute && !o_spk_dma_req && !o_mic_dma_req)
    else $error("soft reset did not hold the unit idle");

  data_loss_set_a: assert property (
    (st_r.mic_en && !st_r.soft_rst && !st_nxt.soft_rst && i_adc_ack && st_r.mic_in_v &&
     st_r.mic_buf_v && !i_mic_dma_ack && !wr_do)
      |=> st_r.f_loss && st_r.mic_in == $past(i_adc_data))
    else $error("overrun did not raise loss flag or overwrite input");

  rx_done_move_a: assert property (
    (st_r.mic_en && !st_r.soft_rst && !st_nxt.soft_rst && st_r.mic_in_v &&
     !st_r.mic_buf_v && !wr_do)
      |=> st_r.f_rx && st_r.mic_buf_v && st_r.mic_buf == $past(st_r.mic_in))
    else $error("buffer load did not raise receive-complete");

  mute_on_gap_a: assert property (
    (st_r.spk_en && !st_r.soft_rst && !st_nxt.soft_rst && spk_tick && !st_r.spk_out_v &&
     st_r.mute_arm) |=> st_r.f_mute && !o_dac_stb)
    else $error("underrun did not raise mute flag");

  spk_refill_a: assert property (
    (st_r.spk_en && !st_r.soft_rst && !st_nxt.soft_rst && !st_r.spk_out_v &&
     st_r.spk_buf_v && !wr_do)
      |=> st_r.spk_out_v && st_r.spk_out == $past(st_r.spk_buf) ##0 o_spk_dma_req)
    else $error("speaker buffer not moved to output then refilled");

  irq_follow_a: assert property ((st_r.f_mute && st_r.m_mute) |-> o_irq)
    else $error("unmasked mute flag without interrupt");

  read_zero_a: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

endmodule : aud_core

/* aud_pkg.sv */
// Purpose : shared constants of the audio unit control and status core
// Assumes : 16-bit registers, each in one aligned 32-bit bus word
// Notes   : byte address of a register is four times its index
package aud_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [31:0] AUD_IDX_VALID   = 32'h0b00_0178;
  localparam logic [31:0] AUD_IDX_SEQ     = 32'h0b00_017a;
  localparam logic [31:0] AUD_IDX_INT     = 32'h0b00_017c;
  localparam logic [31:0] AUD_IDX_MASK    = 32'h0b00_0180;
  localparam logic [31:0] AUD_IDX_SPK_DIV = 32'h0b00_0182;
  localparam logic [31:0] AUD_IDX_MIC_DIV = 32'h0b00_0184;
  localparam logic [31:0] AUD_IDX_SPK_OUT = 32'h0b00_0186;
  localparam logic [31:0] AUD_IDX_SPK_BUF = 32'h0b00_0188;
  localparam logic [31:0] AUD_IDX_MIC_IN  = 32'h0b00_018a;
  localparam logic [31:0] AUD_IDX_MIC_BUF = 32'h0b00_018c;

  localparam logic [31:0] AUD_A_VALID   = {AUD_IDX_VALID[29:0], 2'h0};
  localparam logic [31:0] AUD_A_SEQ     = {AUD_IDX_SEQ[29:0], 2'h0};
  localparam logic [31:0] AUD_A_INT     = {AUD_IDX_INT[29:0], 2'h0};
  localparam logic [31:0] AUD_A_MASK    = {AUD_IDX_MASK[29:0], 2'h0};
  localparam logic [31:0] AUD_A_SPK_DIV = {AUD_IDX_SPK_DIV[29:0], 2'h0};
  localparam logic [31:0] AUD_A_MIC_DIV = {AUD_IDX_MIC_DIV[29:0], 2'h0};
  localparam logic [31:0] AUD_A_SPK_OUT = {AUD_IDX_SPK_OUT[29:0], 2'h0};
  localparam logic [31:0] AUD_A_SPK_BUF = {AUD_IDX_SPK_BUF[29:0], 2'h0};
  localparam logic [31:0] AUD_A_MIC_IN  = {AUD_IDX_MIC_IN[29:0], 2'h0};
  localparam logic [31:0] AUD_A_MIC_BUF = {AUD_IDX_MIC_BUF[29:0], 2'h0};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AUD_B_SPK_OUT_V = 3;
  localparam int AUD_B_SPK_BUF_V = 2;
  localparam int AUD_B_MIC_IN_V  = 1;
  localparam int AUD_B_MIC_BUF_V = 0;
  localparam int AUD_B_SOFT_RST  = 15;
  localparam int AUD_B_MIC_EN    = 4;
  localparam int AUD_B_SPK_EN    = 0;
  localparam int AUD_B_LOSS      = 9;
  localparam int AUD_B_RX_DONE   = 8;
  localparam int AUD_B_MUTE      = 1;

  // ****************************************************************
  // widths, reset values, bus answers
  // ****************************************************************
  localparam int          AUD_SAMPLE_W   = 10;
  localparam logic [15:0] AUD_DIV_RST    = 16'h08dc;
  localparam logic [9:0]  AUD_MIC_IN_IDL = 10'h200;
  localparam logic [9:0]  AUD_SAMPLE_RST = 10'h000;
  localparam logic        AUD_MASK_RST   = 1'h1;
  localparam logic [1:0]  AUD_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  AUD_RESP_SLV   = 2'h2;
  localparam logic [15:0] AUD_ONE16      = 16'h0001;

endpackage : aud_pkg

/* aud_rate_timer.sv */
// Purpose : conversion interval timer, one tick per programmed divisor
// Assumes : divisor counted in clock cycles; zero is taken as one
// Notes   : counter restarts whenever i_run drops
module aud_rate_timer
  import aud_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // control
  input  wire logic        i_run,
  input  wire logic [15:0] i_divisor,
  // event
  output logic             o_tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } aud_tmr_t;

  aud_tmr_t st_r;
  aud_tmr_t st_nxt;

  // ****************************************************************
  // interval count
  // ****************************************************************
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!i_run)
    begin
      st_nxt.cnt = 16'h0000;
    end
    else if (st_r.cnt + AUD_ONE16 >= i_divisor)
    begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + AUD_ONE16;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_tick = st_r.tick;

  tick_spacing_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_tick && i_run && $stable(i_divisor) && i_divisor > 16'h0002) |=> !o_tick ##1 !o_tick)
    else $error("tick came before the programmed interval");

endmodule : aud_rate_timer

/* aud_far_model.sv */
// Purpose : dma controller and a/d converter facing the audio core
// Assumes : acknowledges are one-cycle pulses with their data beside them
// Notes   : data lines invert every cycle once released, so a sample taken one cycle late never matches
module aud_far_model
  import aud_pkg::*;
#(
  parameter logic [AUD_SAMPLE_W-1:0] SPK_BASE = 10'h100,
  parameter logic [AUD_SAMPLE_W-1:0] ADC_BASE = 10'h300
)
(
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  // stall controls
  input  wire logic                    i_hold_spk,
  input  wire logic                    i_hold_mic,
  // speaker dma
  input  wire logic                    i_spk_req,
  output logic                         o_spk_ack,
  output logic [AUD_SAMPLE_W-1:0]      o_spk_data,
  // a/d converter
  input  wire logic                    i_adc_req,
  output logic                         o_adc_ack,
  output logic [AUD_SAMPLE_W-1:0]      o_adc_data,
  // microphone dma
  input  wire logic                    i_mic_req,
  output logic                         o_mic_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [AUD_SAMPLE_W-1:0] spk_n;
  logic [AUD_SAMPLE_W-1:0] adc_n;
  logic                    sa;
  logic                    aa;
  // a stalled dma simply withholds its acknowledge
  assign sa = i_rst_n & i_spk_req & !o_spk_ack & !i_hold_spk;
  assign aa = i_rst_n & i_adc_req;
  initial
  begin
    o_spk_ack = 1'b0;
    o_adc_ack = 1'b0;
    o_mic_ack = 1'b0;
    o_spk_data = 10'h155;
    o_adc_data = 10'h2aa;
  end
  always @(posedge i_mclk)
  begin
    o_spk_ack <= sa;
    o_adc_ack <= aa;
    o_mic_ack <= i_rst_n & i_mic_req & !o_mic_ack & !i_hold_mic;
    o_spk_data <= sa ? SPK_BASE + spk_n : ~o_spk_data;
    o_adc_data <= aa ? ADC_BASE + adc_n : ~o_adc_data;
    spk_n <= !i_rst_n ? '0 : spk_n + AUD_SAMPLE_W'(sa);
    adc_n <= !i_rst_n ? '0 : adc_n + AUD_SAMPLE_W'(aa);
  end
endmodule : aud_far_model

/* tb_audio_unit_valid_enable_irq.sv */
// Purpose : self-checking bench of the audio control and status core
// Assumes : axi4-lite master tasks; far side is aud_far_model
// Notes   : divisors are shortened through their registers
module tb_audio_unit_valid_enable_irq
  import aud_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] SB = 10'h100;
  localparam logic [9:0] AB = 10'h300;
  logic i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, hs, hm;
  logic i_spk_dma_ack, i_adc_ack, i_mic_dma_ack, o_spk_dma_req, o_dac_stb;
  logic o_adc_req, o_mic_dma_req;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, v;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, r;
  logic [9:0] i_spk_dma_data, i_adc_data, o_dac_data, o_mic_dma_data;
  int n_mismatch = 0;
  int cmp_count = 0;
  aud_core u_aud_core (.*);
  aud_far_model #(.SPK_BASE(SB), .ADC_BASE(AB)) u_aud_far_model (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hold_spk(hs), .i_hold_mic(hm),
    .i_spk_req(o_spk_dma_req), .o_spk_ack(i_spk_dma_ack), .o_spk_data(i_spk_dma_data),
    .i_adc_req(o_adc_req), .o_adc_ack(i_adc_ack), .o_adc_data(i_adc_data),
    .i_mic_req(o_mic_dma_req), .o_mic_ack(i_mic_dma_ack));
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wo(input logic [31:0] a, input logic [15:0] d);
    logic ta, tw, b;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= {16'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      @(negedge i_mclk);
      ta = i_awvalid & o_awready;
      tw = i_wvalid & o_wready;
      b = o_bvalid;
      r = o_bresp;
      @(posedge i_mclk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
    end
    while (b !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", 32'(AUD_RESP_OKAY), 32'(r));
  endtask : wo
  task automatic rd(input logic [31:0] a);
    logic ta, t;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      @(negedge i_mclk);
      ta = i_arvalid & o_arready;
      t = o_rvalid;
      v = o_rdata;
      r = o_rresp;
      @(posedge i_mclk);
      if (ta) i_arvalid <= 1'b0;
    end
    while (t !== 1'b1);
    i_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [31:0] a, input logic [15:0] e);
    rd(a);
    chk("rresp", 32'(AUD_RESP_OKAY), 32'(r));
    chk($sformatf("reg %h", a), {16'h0, e}, v);
  endtask : rc
  // poll until a flag shows, bounded so a dead flag cannot hang the run
  task automatic pl(input logic [31:0] a, input logic [15:0] m);
    repeat (200)
    begin
      rd(a);
      if ((v[15:0] & m) == m) break;
    end
  endtask : pl
  task automatic ws(input logic mic);
    repeat (400)
    begin
      @(negedge i_mclk);
      if ((mic ? o_mic_dma_req : o_dac_stb) === 1'b1) break;
    end
  endtask : ws
  task automatic ci(input logic e);
    @(negedge i_mclk);
    chk("irq", 32'(e), 32'(o_irq));
  endtask : ci
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, hm} = '0;
    {i_awaddr, i_wdata, i_araddr} = '0;
    i_wstrb = 4'h3;
    hs = 1'b1;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rc(AUD_A_VALID, 16'h0000);
    rc(AUD_A_INT, 16'h0000);
    rd(32'h0);
    chk("unmapped", 32'(AUD_RESP_SLV), 32'(r));
    wo(AUD_A_VALID, 16'h000f);
    rc(AUD_A_VALID, 16'h0000);
    wo(AUD_A_SEQ, 16'hffff);
    rc(AUD_A_SEQ, 16'h8011);
    wo(AUD_A_SPK_DIV, 16'h0040);
    wo(AUD_A_SEQ, 16'h0001);
    wo(AUD_A_SPK_OUT, 16'h0055);
    rc(AUD_A_VALID, 16'h0000);
    wo(AUD_A_VALID, 16'h0008);
    rc(AUD_A_VALID, 16'h0008);
    ws(1'b0);
    chk("dac", 32'h55, 32'(o_dac_data));
    pl(AUD_A_INT, 16'h0002);
    ci(1'b1);
    wo(AUD_A_INT, 16'h0000);
    rc(AUD_A_INT, 16'h0002);
    wo(AUD_A_SEQ, 16'h8001);
    rc(AUD_A_INT, 16'h0000);
    hs <= 1'b0;
    wo(AUD_A_SEQ, 16'h0001);
    ws(1'b0);
    chk("dac", 32'(SB), 32'(o_dac_data));
    wo(AUD_A_SEQ, 16'h0000);
    rc(AUD_A_VALID, 16'h0000);
    wo(AUD_A_INT, 16'h0002);
    rc(AUD_A_INT, 16'h0000);
    wo(AUD_A_MIC_DIV, 16'h0010);
    wo(AUD_A_SEQ, 16'h0010);
    ws(1'b1);
    chk("micdma", 32'(AB), 32'(o_mic_dma_data));
    pl(AUD_A_INT, 16'h0100);
    rc(AUD_A_INT, 16'h0100);
    hm <= 1'b1;
    pl(AUD_A_INT, 16'h0200);
    rc(AUD_A_INT, 16'h0300);
    rc(AUD_A_VALID, 16'h0003);
    wo(AUD_A_MASK, 16'h0000);
    ci(1'b0);
    wo(AUD_A_SEQ, 16'h0000);
    rc(AUD_A_VALID, 16'h0000);
    wo(AUD_A_INT, 16'h0200);
    rc(AUD_A_INT, 16'h0100);
    wo(AUD_A_MASK, 16'h0302);
    ci(1'b1);
    wo(AUD_A_INT, 16'h0100);
    ci(1'b0);
    tally_and_finish;
  end
endmodule : tb_audio_unit_valid_enable_irq
